// *** rtl/vcfs_defs.svh ***
// Constants for the vehicle control frame sequencer.
// Assumes a 100 MHz clock; included by bare name.
`ifndef VCFS_DEFS_SVH
`define VCFS_DEFS_SVH
`define VCFS_CLK_MHZ 100
`define VCFS_TICK_MS 10
`define VCFS_TICK_CYC (`VCFS_TICK_MS * 1000 * `VCFS_CLK_MHZ)
`define VCFS_INIT_S 30
`define VCFS_INIT_TICKS (`VCFS_INIT_S * 1000 / `VCFS_TICK_MS)
`define VCFS_MSG_TMO_MS 400
`define VCFS_MSG_TMO_TICKS (`VCFS_MSG_TMO_MS / `VCFS_TICK_MS)
`define VCFS_FRAMES 4
`define VCFS_HIST 5
`define VCFS_WHEELS 4
`define VCFS_KEY_FULL 2'h3
`define VCFS_KEY_STEP1 2'h1
`define VCFS_KEY_STEP2 2'h2
`define VCFS_READY_A 8'hA5
`define VCFS_READY_B 8'h5A
// AXI4-Lite map
`define VCFS_A_CTRL 8'h00
`define VCFS_A_STAT 8'h04
`define VCFS_A_CAL0 8'h08
`define VCFS_A_CAL1 8'h0C
`define VCFS_A_ODO_SEL 8'h10
`define VCFS_A_ODO_CNT 8'h14
`define VCFS_A_ODO_TIM 8'h18
`define VCFS_A_MSG_TMO 8'h1C
`define VCFS_CAL_DEFAULT 16'h1000
`define VCFS_CAL_MIN 16'h0C00
`define VCFS_CAL_MAX 16'h1400
`define VCFS_RESP_OK 2'h0
`define VCFS_RESP_SLVERR 2'h2
`endif

// *** rtl/vcfs_pkg.sv ***
// Types for the vehicle control frame sequencer.
// Assumes vcfs_defs.svh is compiled alongside.
package vcfs_pkg;
  typedef enum logic [5:0] {
    VCFS_ST_BOOT = 6'h01,
    VCFS_ST_INIT = 6'h02,
    VCFS_ST_SYNC = 6'h04,
    VCFS_ST_RUN = 6'h08,
    VCFS_ST_MON = 6'h10,
    VCFS_ST_HALT = 6'h20
  } vcfs_state_e;
endpackage : vcfs_pkg

// *** rtl/vcfs_sequencer.sv ***
// Frame sequencer and safety gate for one redundant processor channel.
// Assumes a 100 MHz clk, async reset_n, AXI4-Lite master on the bus,
// and twin/comm ready words on plain ports.
// Operation
// - Ten millisecond tick starts minor frame; four frames form major.
// - Each frame runs common input phase before its specific function.
// - Intact key: one holdoff pulse and torque forwarded per tick.
// - Broken key: holdoff pulse and torque command suppressed.
// - Any self-check failure clears the punch-in key.
// - Background check failure halts outside boot; no further ticks acknowledged.
// - Both forward or both aft safe, else closed loop stop.
// - New closed loop stop restarts cycle at minor frame one.
// - Keep counts and last pulse times for five frames.
// - Carrier present, no message for 400 ms of run ticks: normal stop.
// - In init only tick and monitor interrupts; others halt.
// - Init tick increments duration timer and sets step flag.
// - Thirty second window; inside it check comm ready, set own; expiry halts.
// - Sync on twin ready sequence; control begins next tick.
// - Key built in two steps: software init, then integrity.
// - Bad calibration factor in init cleared to default, fault queued.
// - Hard-wired input selects prime channel.
// - Cal default request sampled per tick; loads defaults.
// - Monitor request honoured only at rest; stops control.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "vcfs_defs.svh"
module vcfs_sequencer import vcfs_pkg::*; #(
  parameter int TICK_CYC = `VCFS_TICK_CYC,
  parameter int INIT_TICKS = `VCFS_INIT_TICKS,
  parameter int MSG_TICKS = `VCFS_MSG_TMO_TICKS,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  // Pins, asynchronous to clk
  input wire logic [1:0] safe_fwd,
  input wire logic [1:0] safe_aft,
  input wire logic cal_default_req,
  input wire logic monitor_req,
  input wire logic monitor_btn,
  input wire logic other_irq,
  input wire logic prime_strap,
  input wire logic carrier_present,
  input wire logic msg_strobe,
  input wire logic [3:0] odo_pulse,
  // Same-clock status from other logic
  input wire logic vehicle_at_rest,
  input wire logic bg_fail,
  input wire logic self_check_fail,
  input wire logic init_checks_ok,
  input wire logic comm_ready,
  input wire logic [7:0] twin_ready_word,
  input wire logic [15:0] twin_cal0,
  input wire logic [15:0] twin_cal1,
  input wire logic [15:0] torque_in,
  // Outputs
  output logic holdoff_pulse,
  output logic [15:0] torque_cmd,
  output logic closed_loop_estop_cmd,
  output logic normal_stop_cmd,
  output logic [3:0] frame_onehot,
  output logic common_phase,
  output logic frame_func,
  output logic init_step_flag,
  output logic [7:0] own_ready_word,
  output logic is_prime,
  output logic fault_push,
  output logic halted,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NP = 16;
  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  // Three-flop pin filter; value moves only when flops 2 and 3 agree
  logic [NP-1:0] pin_raw, p1_q, p2_q, p3_q, pin_q;
  assign pin_raw = {msg_strobe, carrier_present, prime_strap, other_irq,
                    monitor_btn, monitor_req, cal_default_req, safe_aft,
                    safe_fwd, odo_pulse, 1'h0};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
      pin_q <= '0;
    end else begin
      p1_q <= pin_raw;
      p2_q <= p1_q;
      p3_q <= p2_q;
      pin_q <= (p2_q & p3_q) | (pin_q & (p2_q | p3_q));
    end
  end
  logic [3:0] odo_s;
  logic [1:0] fwd_s, aft_s;
  logic cal_s, monr_s, monb_s, oirq_s, prime_s, carr_s, msg_s;
  assign odo_s = pin_q[4:1];
  assign fwd_s = pin_q[6:5];
  assign aft_s = pin_q[8:7];
  assign cal_s = pin_q[9];
  assign monr_s = pin_q[10];
  assign monb_s = pin_q[11];
  assign oirq_s = pin_q[12];
  assign prime_s = pin_q[13];
  assign carr_s = pin_q[14];
  assign msg_s = pin_q[15];

  // Master clock tick every ten milliseconds
  logic [31:0] tick_cnt_q;
  logic tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_q <= '0;
    else if (tick) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

  // Software control register fields
  logic sw_go_q, key_step2_req_q, msg_tmo_en_q;
  logic [15:0] cal0_q, cal1_q;
  logic [1:0] odo_sel_q;

  // Main state machine
  vcfs_state_e st_q;
  logic [15:0] init_ticks_q;
  logic [1:0] key_q;
  logic key_ok;
  logic halt_cause;
  assign key_ok = (key_q == `VCFS_KEY_FULL);
  // Halt: background failure, or stray interrupt during init or sync
  assign halt_cause = bg_fail ||
      ((st_q == VCFS_ST_INIT || st_q == VCFS_ST_SYNC) && oirq_s);
  logic twin_seen_a_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= VCFS_ST_BOOT;
      init_ticks_q <= '0;
      init_step_flag <= 1'h0;
      own_ready_word <= 8'h00;
      twin_seen_a_q <= 1'h0;
      halted <= 1'h0;
    end else begin
      init_step_flag <= 1'h0;
      halted <= st_q == VCFS_ST_HALT;
      case (st_q)
        VCFS_ST_BOOT: if (sw_go_q) st_q <= VCFS_ST_INIT;
        VCFS_ST_INIT: begin
          if (halt_cause) st_q <= VCFS_ST_HALT;
          else if (monb_s) st_q <= VCFS_ST_MON;
          else begin
            if (tick) begin
              init_ticks_q <= init_ticks_q + 16'h1;
              init_step_flag <= 1'h1;
            end
            // Pass only inside the window and with comm ready
            if (init_checks_ok && key_ok && comm_ready &&
                init_ticks_q < 16'(INIT_TICKS)) begin
              own_ready_word <= `VCFS_READY_A;
              st_q <= VCFS_ST_SYNC;
            end else if (init_ticks_q >= 16'(INIT_TICKS))
              st_q <= VCFS_ST_HALT;
          end
        end
        VCFS_ST_SYNC: begin
          // A then B sequence: a stuck word never reads as ready
          if (halt_cause) st_q <= VCFS_ST_HALT;
          else if (twin_ready_word == `VCFS_READY_A) begin
            twin_seen_a_q <= 1'h1;
            own_ready_word <= `VCFS_READY_B;
          end else if (twin_seen_a_q &&
                       twin_ready_word == `VCFS_READY_B && tick)
            st_q <= VCFS_ST_RUN;
        end
        VCFS_ST_RUN: begin
          if (halt_cause) st_q <= VCFS_ST_HALT;
          else if (monr_s && vehicle_at_rest) st_q <= VCFS_ST_MON;
        end
        VCFS_ST_MON: if (bg_fail) st_q <= VCFS_ST_HALT;
        VCFS_ST_HALT: st_q <= VCFS_ST_HALT;
        default: st_q <= VCFS_ST_HALT;
      endcase
    end
  end

  // Punch-in key: two build steps, cleared by failure, never rebuilt
  logic key_dead_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= 2'h0;
      key_dead_q <= 1'h0;
    end else if (self_check_fail || bg_fail || st_q == VCFS_ST_HALT ||
                 key_dead_q) begin
      key_q <= 2'h0;
      key_dead_q <= 1'h1;
    end else if (st_q == VCFS_ST_INIT) begin
      if (key_q == 2'h0) key_q <= `VCFS_KEY_STEP1;
      else if (key_q == `VCFS_KEY_STEP1 && key_step2_req_q)
        key_q <= key_q | `VCFS_KEY_STEP2;
    end
  end

  // Frame phase: common input cycle, then frame function cycle
  logic run_tick;
  logic [1:0] frame_idx_q;
  logic estop_q, estop_new;
  logic safe_vote;
  assign run_tick = tick && st_q == VCFS_ST_RUN && !halt_cause;
  assign safe_vote = (&fwd_s) || (&aft_s);
  assign estop_new = run_tick && !safe_vote && !estop_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_idx_q <= 2'h3;
      frame_onehot <= 4'h0;
      common_phase <= 1'h0;
      frame_func <= 1'h0;
      closed_loop_estop_cmd <= 1'h0;
      estop_q <= 1'h0;
    end else begin
      common_phase <= run_tick;
      frame_func <= common_phase;
      if (run_tick) begin
        estop_q <= !safe_vote;
        closed_loop_estop_cmd <= !safe_vote;
        if (estop_new) begin
          frame_idx_q <= 2'h0;
          frame_onehot <= 4'h1;
        end else begin
          frame_idx_q <= frame_idx_q + 2'h1;
          frame_onehot <= 4'h1 << (frame_idx_q + 2'h1);
        end
      end
    end
  end

  // Holdoff pulse and torque gated by key each tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdoff_pulse <= 1'h0;
      torque_cmd <= 16'h0000;
    end else begin
      holdoff_pulse <= run_tick && key_ok;
      if (run_tick) torque_cmd <= key_ok ? torque_in : 16'h0000;
      else if (!key_ok) torque_cmd <= 16'h0000;
    end
  end

  // Odometer counts and last pulse times, five frame history
  logic [CNT_W-1:0] odo_cnt_q [`VCFS_WHEELS];
  logic [31:0] odo_tim_q [`VCFS_WHEELS];
  logic [CNT_W-1:0] hist_cnt_q [`VCFS_HIST][`VCFS_WHEELS];
  logic [31:0] hist_tim_q [`VCFS_HIST][`VCFS_WHEELS];
  logic [31:0] time_q;
  logic [3:0] odo_d1_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_q <= '0;
      odo_d1_q <= '0;
      for (int w = 0; w < `VCFS_WHEELS; w++) begin
        odo_cnt_q[w] <= '0;
        odo_tim_q[w] <= '0;
        for (int h = 0; h < `VCFS_HIST; h++) begin
          hist_cnt_q[h][w] <= '0;
          hist_tim_q[h][w] <= '0;
        end
      end
    end else begin
      time_q <= time_q + 32'h1;
      odo_d1_q <= odo_s;
      for (int w = 0; w < `VCFS_WHEELS; w++) begin
        if (odo_s[w] && !odo_d1_q[w]) begin
          odo_cnt_q[w] <= odo_cnt_q[w] + 1'b1;
          odo_tim_q[w] <= time_q;
        end
        if (run_tick) begin
          hist_cnt_q[0][w] <= odo_cnt_q[w];
          hist_tim_q[0][w] <= odo_tim_q[w];
          for (int h = 1; h < `VCFS_HIST; h++) begin
            hist_cnt_q[h][w] <= hist_cnt_q[h-1][w];
            hist_tim_q[h][w] <= hist_tim_q[h-1][w];
          end
        end
      end
    end
  end

  // Uplink message timeout, counted in ticks
  logic [15:0] msg_age_q;
  logic msg_d1_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_age_q <= '0;
      msg_d1_q <= 1'h0;
      normal_stop_cmd <= 1'h0;
    end else begin
      msg_d1_q <= msg_s;
      if (!carr_s || (msg_s && !msg_d1_q)) msg_age_q <= '0;
      else if (run_tick && msg_age_q < 16'(MSG_TICKS))
        msg_age_q <= msg_age_q + 16'h1;
      if (msg_tmo_en_q && carr_s && msg_age_q >= 16'(MSG_TICKS))
        normal_stop_cmd <= 1'h1;
      else if (!carr_s || msg_age_q < 16'(MSG_TICKS))
        normal_stop_cmd <= 1'h0;
    end
  end

  // Prime strap and calibration checks
  logic cal_bad;
  assign cal_bad = cal0_q != twin_cal0 || cal1_q != twin_cal1 ||
      cal0_q < `VCFS_CAL_MIN || cal0_q > `VCFS_CAL_MAX ||
      cal1_q < `VCFS_CAL_MIN || cal1_q > `VCFS_CAL_MAX;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) is_prime <= 1'h0;
    else is_prime <= prime_s;
  end

  // AXI4-Lite write path; cal factors also written by hardware
  logic aw_full_q, w_full_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic do_wr;
  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'h0;
      w_full_q <= 1'h0;
      aw_q <= '0;
      wd_q <= '0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `VCFS_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'h1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'h1;
        wd_q <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_full_q <= 1'h0;
        w_full_q <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= (aw_q == `VCFS_A_CTRL || aw_q == `VCFS_A_CAL0 ||
            aw_q == `VCFS_A_CAL1 || aw_q == `VCFS_A_ODO_SEL ||
            aw_q == `VCFS_A_STAT || aw_q == `VCFS_A_ODO_CNT ||
            aw_q == `VCFS_A_ODO_TIM || aw_q == `VCFS_A_MSG_TMO) ?
            `VCFS_RESP_OK : `VCFS_RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
    end else begin
      s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_go_q <= 1'h0;
      key_step2_req_q <= 1'h0;
      msg_tmo_en_q <= 1'h1;
      odo_sel_q <= 2'h0;
      cal0_q <= `VCFS_CAL_DEFAULT;
      cal1_q <= `VCFS_CAL_DEFAULT;
      fault_push <= 1'h0;
    end else begin
      fault_push <= 1'h0;
      if (do_wr && aw_q == `VCFS_A_CTRL && s_axi_wstrb[0]) begin
        sw_go_q <= wd_q[0];
        key_step2_req_q <= wd_q[1];
        msg_tmo_en_q <= wd_q[2];
      end
      if (do_wr && aw_q == `VCFS_A_ODO_SEL && s_axi_wstrb[0])
        odo_sel_q <= wd_q[1:0];
      // Hardware default load beats a software write in the same cycle
      if (tick && cal_s) begin
        cal0_q <= `VCFS_CAL_DEFAULT;
        cal1_q <= `VCFS_CAL_DEFAULT;
      end else if (st_q == VCFS_ST_INIT && cal_bad) begin
        cal0_q <= `VCFS_CAL_DEFAULT;
        cal1_q <= `VCFS_CAL_DEFAULT;
        fault_push <= 1'h1;
      end else if (do_wr && aw_q == `VCFS_A_CAL0 && &s_axi_wstrb[1:0])
        cal0_q <= wd_q[15:0];
      else if (do_wr && aw_q == `VCFS_A_CAL1 && &s_axi_wstrb[1:0])
        cal1_q <= wd_q[15:0];
    end
  end

  // AXI4-Lite read path, one answer per address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `VCFS_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rresp <= `VCFS_RESP_OK;
        case (s_axi_araddr)
          `VCFS_A_CTRL: s_axi_rdata <= {29'h0, msg_tmo_en_q,
                                        key_step2_req_q, sw_go_q};
          `VCFS_A_STAT: s_axi_rdata <= {4'h0, init_ticks_q, frame_onehot,
                                        2'h0, st_q};
          `VCFS_A_CAL0: s_axi_rdata <= {16'h0000, cal0_q};
          `VCFS_A_CAL1: s_axi_rdata <= {16'h0000, cal1_q};
          `VCFS_A_ODO_SEL: s_axi_rdata <= {30'h0, odo_sel_q};
          `VCFS_A_ODO_CNT: s_axi_rdata <= 32'(odo_cnt_q[odo_sel_q]);
          `VCFS_A_ODO_TIM: s_axi_rdata <= odo_tim_q[odo_sel_q];
          `VCFS_A_MSG_TMO: s_axi_rdata <= {16'h0000, msg_age_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `VCFS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'h0;
    end
  end

endmodule : vcfs_sequencer

// *** tb/vcfs_sequencer_chk.sv ***
// Port checker for the frame sequencer.
// Assumes a bind onto vcfs_sequencer and a single clock domain.
`timescale 1ns/1ns
module vcfs_sequencer_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic holdoff_pulse,
  input wire logic closed_loop_estop_cmd,
  input wire logic [3:0] frame_onehot,
  input wire logic common_phase,
  input wire logic frame_func,
  input wire logic init_step_flag,
  input wire logic halted,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // Raw reset; outputs are zero while it is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_order;
    $changed(frame_onehot) && $past(frame_onehot) != 4'h0 &&
      frame_onehot != 4'h0 |-> frame_onehot == 4'h1 ||
      $past(frame_onehot) == {frame_onehot[0], frame_onehot[3:1]};
  endproperty
  a_order: assert property (p_order) else $error("frame order");
  property p_restart;
    $rose(closed_loop_estop_cmd) |-> ##[0:4] frame_onehot == 4'h1;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_phase;
    common_phase |=> frame_func && $onehot(frame_onehot);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_pulse;
    holdoff_pulse |=> !holdoff_pulse [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("holdoff twice");
  property p_sticky;
    halted |=> halted;
  endproperty
  a_sticky: assert property (p_sticky) else $error("halt left");
  property p_quiet;
    halted && $past(halted) |-> !holdoff_pulse && !init_step_flag &&
      !common_phase;
  endproperty
  a_quiet: assert property (p_quiet) else $error("halt not quiet");
  property p_step;
    init_step_flag |-> frame_onehot == 4'h0 ##1 !init_step_flag;
  endproperty
  a_step: assert property (p_step) else $error("init step");
  property p_bresp;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp: assert property (p_bresp) else $error("bresp dropped");
endmodule : vcfs_sequencer_chk

bind vcfs_sequencer vcfs_sequencer_chk i_vcfs_sequencer_chk (
  .clk(clk), .reset_n(reset_n), .holdoff_pulse(holdoff_pulse),
  .closed_loop_estop_cmd(closed_loop_estop_cmd),
  .frame_onehot(frame_onehot), .common_phase(common_phase),
  .frame_func(frame_func), .init_step_flag(init_step_flag),
  .halted(halted), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// *** tb/vcfs_twin.sv ***
// Model of the twin channel: ready word and stored cal factors.
// Assumes the same clk and reset_n as the channel under test.
`timescale 1ns/1ns
module vcfs_twin #(
  parameter int DLY = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] own_ready_word,
  output logic [7:0] twin_ready_word,
  output logic [15:0] twin_cal0,
  output logic [15:0] twin_cal1
);
  int cnt_q;
  // Matching defaults, so no cal disagreement is raised
  assign twin_cal0 = 16'h1000;
  assign twin_cal1 = 16'h1000;
  // Word stays zero while dead; A5, then 5A only after ours shows A5
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
      twin_ready_word <= 8'h00;
    end else if (cnt_q < DLY) begin
      cnt_q <= cnt_q + 1;
    end else if (twin_ready_word == 8'h00) begin
      twin_ready_word <= 8'hA5;
    end else if (own_ready_word == 8'hA5) begin
      twin_ready_word <= 8'h5A;
    end
  end
endmodule : vcfs_twin

// *** tb/tb_top.sv ***
// Self-checking bench for the frame sequencer with its twin model.
// Assumes scaled tick, init and message counts and a 100 MHz clock.
`timescale 1ns/1ns
`include "vcfs_defs.svh"
module tb_top;
  logic clk, reset_n, cal_default_req, monitor_req, monitor_btn;
  logic other_irq, prime_strap, carrier_present, msg_strobe, is_prime;
  logic vehicle_at_rest, bg_fail, self_check_fail, init_checks_ok;
  logic comm_ready, holdoff_pulse, closed_loop_estop_cmd, halted;
  logic normal_stop_cmd, common_phase, frame_func, init_step_flag;
  logic fault_push, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] safe_fwd, safe_aft, s_axi_bresp, s_axi_rresp, r;
  logic [3:0] odo_pulse, frame_onehot, s_axi_wstrb;
  logic [7:0] twin_ready_word, own_ready_word, s_axi_awaddr, s_axi_araddr;
  logic [15:0] twin_cal0, twin_cal1, torque_in, torque_cmd;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int errors, check_count, h;
  localparam int W_RUN = 0, W_STOP = 1, W_FUNC = 2, W_HALT = 3;
  localparam int W_NSTOP = 4, W_RDY = 5;
  // Short counts keep each tick at 20 cycles
  vcfs_sequencer #(.TICK_CYC(20), .INIT_TICKS(10), .MSG_TICKS(4))
    i_vcfs_sequencer (.*);
  vcfs_twin i_vcfs_twin (.*);
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk
  task automatic tmo(int n, int lim);
    if (n >= lim) begin
      errors++;
      report_and_stop;
    end
  endtask : tmo
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  function automatic logic pick(int s);
    case (s)
      W_RUN: return frame_onehot != 4'h0;
      W_STOP: return closed_loop_estop_cmd;
      W_FUNC: return frame_func;
      W_HALT: return halted;
      W_NSTOP: return normal_stop_cmd;
      default: return own_ready_word != 8'h00;
    endcase
  endfunction : pick
  // Bounded wait for a level; running out ends the run
  task automatic wait_on(int s, logic v, int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    tmo(n, lim);
  endtask : wait_on
  task automatic count_holdoff(int k);
    h = 0;
    repeat (k) begin
      @(posedge clk);
      h += int'(holdoff_pulse === 1'b1);
    end
  endtask : count_holdoff
  // Address and data go out together; each drops once taken
  task automatic axi_wr(logic [7:0] a, logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    tmo(n, 200);
  endtask : axi_wr
  task automatic axi_rd(logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    tmo(n, 200);
  endtask : axi_rd
  task automatic do_reset;
    reset_n <= 1'b0;
    cyc(6);
    reset_n <= 1'b1;
    cyc(4);
  endtask : do_reset
  task automatic t_bus;
    chk("frame", 0, frame_onehot);
    axi_rd(`VCFS_A_CTRL);
    chk("ctrl", 4, d[2:0]);
    axi_rd(8'h40);
    chk("rresp", `VCFS_RESP_SLVERR, r);
    axi_wr(8'h40, 32'h0);
    chk("bresp", `VCFS_RESP_SLVERR, r);
    axi_wr(`VCFS_A_STAT, 32'hFFFF_FFFF);
    chk("ro bresp", `VCFS_RESP_OK, r);
    $display("t_bus done");
  endtask : t_bus
  task automatic t_init;
    axi_wr(`VCFS_A_CTRL, 32'h5);
    h = 0;
    repeat (61) begin
      @(posedge clk);
      h += int'(init_step_flag === 1'b1);
    end
    chk("init steps", 3, h);
    chk("ready early", 0, own_ready_word);
    axi_wr(`VCFS_A_CTRL, 32'h7);
    init_checks_ok <= 1'b1;
    comm_ready <= 1'b1;
    wait_on(W_RDY, 1'b1, 400);
    chk("ready a", `VCFS_READY_A, own_ready_word);
    wait_on(W_RUN, 1'b1, 400);
    chk("ready b", `VCFS_READY_B, own_ready_word);
    chk("prime", 1, is_prime);
    $display("t_init done");
  endtask : t_init
  task automatic t_frames;
    logic [3:0] f;
    int n;
    f = 4'h0;
    h = 0;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
        if (k > 0) h += int'(holdoff_pulse === 1'b1);
      end while (frame_func !== 1'b1 && n < 40);
      tmo(n, 40);
      if (k > 0) chk("frame", {f[2:0], f[3]}, frame_onehot);
      f = frame_onehot;
    end
    chk("holdoffs", 7, h);
    chk("torque", torque_in, torque_cmd);
    $display("t_frames done");
  endtask : t_frames
  task automatic t_estop;
    safe_fwd <= 2'b01;
    safe_aft <= 2'b10;
    wait_on(W_STOP, 1'b1, 60);
    chk("estop", 1, closed_loop_estop_cmd);
    wait_on(W_FUNC, 1'b1, 30);
    chk("restart", 1, frame_onehot);
    safe_fwd <= 2'b00;
    safe_aft <= 2'b11;
    wait_on(W_STOP, 1'b0, 60);
    chk("aft pair", 0, closed_loop_estop_cmd);
    safe_fwd <= 2'b11;
    $display("t_estop done");
  endtask : t_estop
  task automatic t_cal;
    axi_wr(`VCFS_A_CAL0, 32'h1200);
    axi_rd(`VCFS_A_CAL0);
    chk("cal0", 16'h1200, d[15:0]);
    cal_default_req <= 1'b1;
    cyc(45);
    cal_default_req <= 1'b0;
    axi_rd(`VCFS_A_CAL0);
    chk("cal0 dflt", `VCFS_CAL_DEFAULT, d[15:0]);
    axi_rd(`VCFS_A_CAL1);
    chk("cal1 dflt", `VCFS_CAL_DEFAULT, d[15:0]);
    $display("t_cal done");
  endtask : t_cal
  task automatic t_msg;
    carrier_present <= 1'b1;
    repeat (5) begin
      msg_strobe <= 1'b1;
      cyc(3);
      msg_strobe <= 1'b0;
      cyc(37);
    end
    chk("nstop early", 0, normal_stop_cmd);
    wait_on(W_NSTOP, 1'b1, 200);
    chk("nstop", 1, normal_stop_cmd);
    $display("t_msg done");
  endtask : t_msg
  task automatic t_halt;
    self_check_fail <= 1'b1;
    @(posedge clk);
    self_check_fail <= 1'b0;
    cyc(25);
    count_holdoff(60);
    chk("holdoff off", 0, h);
    chk("torque off", 0, torque_cmd);
    bg_fail <= 1'b1;
    @(posedge clk);
    bg_fail <= 1'b0;
    wait_on(W_HALT, 1'b1, 20);
    cyc(60);
    chk("halt held", 1, halted);
    $display("t_halt done");
  endtask : t_halt
  task automatic t_init_fail;
    do_reset();
    init_checks_ok <= 1'b0;
    axi_wr(`VCFS_A_CTRL, 32'h5);
    cyc(100);
    chk("halt early", 0, halted);
    wait_on(W_HALT, 1'b1, 300);
    do_reset();
    axi_wr(`VCFS_A_CTRL, 32'h5);
    other_irq <= 1'b1;
    cyc(3);
    other_irq <= 1'b0;
    wait_on(W_HALT, 1'b1, 20);
    chk("irq halt", 1, halted);
    do_reset();
    axi_wr(`VCFS_A_CTRL, 32'h5);
    monitor_btn <= 1'b1;
    cyc(6);
    axi_rd(`VCFS_A_STAT);
    chk("mon", 6'h10, d[5:0]);
    $display("t_init_fail done");
  endtask : t_init_fail
  // Every input set at time zero, then the scenarios in order
  initial begin
    errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    {safe_fwd, safe_aft} = 4'hF;
    {cal_default_req, monitor_req, monitor_btn, other_irq} = 4'h0;
    {carrier_present, msg_strobe, vehicle_at_rest, bg_fail} = 4'h0;
    {self_check_fail, init_checks_ok, comm_ready} = 3'h0;
    prime_strap = 1'b1;
    odo_pulse = 4'h0;
    torque_in = 16'h1234;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    do_reset();
    t_bus();
    t_init();
    t_frames();
    t_estop();
    t_cal();
    t_msg();
    t_halt();
    t_init_fail();
    report_and_stop();
  end
endmodule : tb_top
